/* src/xevt_top.sv */
// External line event unit with AXI4-Lite registers
`include "xevt_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module xevt_top
    import xevt_pkg::*;
#(
    parameter int NPORT = 8
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      ce,
    input  wire logic [NPORT*16-1:0]       gpio_in,
    input  wire logic [7:0]                int_line_in,
    input  wire logic [`XEVT_AW-1:0]       s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [`XEVT_AW-1:0]       s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic                           irq,
    output logic [`XEVT_NLINE-1:0]         line_req,
    output logic [`XEVT_NLINE-1:0]         evt_pulse
);
    localparam int NL = `XEVT_NLINE;

    if (NPORT < 1 || NPORT > (1 << `XEVT_SELW)) begin : g_chk
        $error("NPORT must lie between 1 and 16");
    end

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = 32'h00000000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{s[b]}};
        end
        return m;
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [31:0] m);
        return (old & ~m) | (d & m);
    endfunction
    function automatic logic [NL-1:0] merge_line(input logic [NL-1:0] old,
            input logic [31:0] d, input logic [31:0] m);
        return (old & ~m[NL-1:0]) | (d[NL-1:0] & m[NL-1:0]);
    endfunction

    // Register state
    logic [NL-1:0]   imr_r, imr_nxt;
    logic [NL-1:0]   emr_r, emr_nxt;
    logic [NL-1:0]   rise_r, rise_nxt;
    logic [NL-1:0]   fall_r, fall_nxt;
    logic [NL-1:0]   pend_r, pend_nxt;
    logic [NL-1:0]   evt_r, evt_nxt;
    logic [NL-1:0]   req_r, req_nxt;
    logic            irq_r, irq_nxt;
    logic [63:0]     sel_r, sel_nxt;
    logic            run_r, run_nxt;
    // Crossing state
    logic [NL-1:0]   rs1_r, rs2_r, rp_r;
    logic [NL-1:0]   fs1_r, fs2_r, fp_r;
    logic [NL-1:0]   rs1_nxt, rs2_nxt, rp_nxt;
    logic [NL-1:0]   fs1_nxt, fs2_nxt, fp_nxt;
    // Bus state
    logic              awrdy_r, awrdy_nxt;
    logic              wrdy_r, wrdy_nxt;
    logic              bvld_r, bvld_nxt;
    logic [1:0]        bresp_r, bresp_nxt;
    logic [`XEVT_AW-1:0] awa_r, awa_nxt;
    logic [31:0]       wd_r, wd_nxt;
    logic [3:0]        ws_r, ws_nxt;
    logic              arrdy_r, arrdy_nxt;
    logic              rvld_r, rvld_nxt;
    logic [31:0]       rd_r, rd_nxt;
    logic [1:0]        rresp_r, rresp_nxt;

    logic [NL-1:0]   src;
    logic [NL-1:0]   rtog, ftog;
    logic [NL-1:0]   edge_v;
    logic [NL-1:0]   swt_v, clr_v;
    logic            do_wr;

    // Pin selector; lines 16 up carry internal event sources
    always_comb begin
        src = {int_line_in, 16'h0000};
        for (int i = 0; i < `XEVT_NPIN; i++) begin
            if (int'(sel_r[i*4 +: 4]) < NPORT) begin
                src[i] = gpio_in[int'(sel_r[i*4 +: 4]) * 16 + i]; // R06
            end
        end
    end

    // Pin-clocked toggles catch any pulse width, then cross into aclk
    for (genvar g = 0; g < NL; g++) begin : g_cat
        logic rt, ft;
        always_ff @(posedge src[g] or negedge run_r) begin
            if (!run_r) begin
                rt <= 1'b0;
            end else begin
                rt <= ~rt; // R05
            end
        end
        always_ff @(negedge src[g] or negedge run_r) begin
            if (!run_r) begin
                ft <= 1'b0;
            end else begin
                ft <= ~ft; // R05
            end
        end
        assign rtog[g] = rt;
        assign ftog[g] = ft;
    end

    // Edge detection and pending
    always_comb begin
        rs1_nxt = rtog;
        rs2_nxt = rs1_r;
        rp_nxt  = rs2_r;
        fs1_nxt = ftog;
        fs2_nxt = fs1_r;
        fp_nxt  = fs2_r;
        run_nxt = 1'b1;
        do_wr   = !awrdy_r && !wrdy_r && !bvld_r;
        swt_v   = '0;
        clr_v   = '0;
        if (do_wr && awa_r == `XEVT_OFF_SWT) begin
            swt_v = merge_line('0, wd_r, strb_mask(ws_r));
        end
        if (do_wr && awa_r == `XEVT_OFF_PEND) begin
            clr_v = merge_line('0, wd_r, strb_mask(ws_r));
        end
        edge_v = ((rs2_r ^ rp_r) & rise_r)      // R02
               | ((fs2_r ^ fp_r) & fall_r)      // R02
               | swt_v;
        pend_nxt = (pend_r & ~clr_v) | edge_v;  // R04 R08
        evt_nxt  = edge_v & emr_r;              // R01
        req_nxt  = pend_nxt & imr_nxt;          // R03 R08
        irq_nxt  = |req_nxt;                    // R01 R08
    end

    // Register bus
    always_comb begin
        awrdy_nxt = awrdy_r;
        wrdy_nxt  = wrdy_r;
        bvld_nxt  = bvld_r;
        bresp_nxt = bresp_r;
        awa_nxt   = awa_r;
        wd_nxt    = wd_r;
        ws_nxt    = ws_r;
        arrdy_nxt = arrdy_r;
        rvld_nxt  = rvld_r;
        rd_nxt    = rd_r;
        rresp_nxt = rresp_r;
        imr_nxt   = imr_r;
        emr_nxt   = emr_r;
        rise_nxt  = rise_r;
        fall_nxt  = fall_r;
        sel_nxt   = sel_r;
        if (s_axi_awvalid && awrdy_r) begin
            awa_nxt   = s_axi_awaddr;
            awrdy_nxt = 1'b0;
        end
        if (s_axi_wvalid && wrdy_r) begin
            wd_nxt   = s_axi_wdata;
            ws_nxt   = s_axi_wstrb;
            wrdy_nxt = 1'b0;
        end
        if (bvld_r && s_axi_bready) begin
            bvld_nxt = 1'b0;
        end
        if (do_wr) begin
            awrdy_nxt = 1'b1;
            wrdy_nxt  = 1'b1;
            bvld_nxt  = 1'b1;
            bresp_nxt = XEVT_OKAY;
            if (awa_r == `XEVT_OFF_IMR) begin
                imr_nxt = merge_line(imr_r, wd_r, strb_mask(ws_r)); // R03
            end else if (awa_r == `XEVT_OFF_EMR) begin
                emr_nxt = merge_line(emr_r, wd_r, strb_mask(ws_r));
            end else if (awa_r == `XEVT_OFF_RISE) begin
                rise_nxt = merge_line(rise_r, wd_r, strb_mask(ws_r)); // R02
            end else if (awa_r == `XEVT_OFF_FALL) begin
                fall_nxt = merge_line(fall_r, wd_r, strb_mask(ws_r)); // R02
            end else if (awa_r == `XEVT_OFF_SEL0) begin
                sel_nxt[31:0] = merge(sel_r[31:0], wd_r, strb_mask(ws_r)); // R06
            end else if (awa_r == `XEVT_OFF_SEL1) begin
                sel_nxt[63:32] = merge(sel_r[63:32], wd_r, strb_mask(ws_r)); // R06
            end else if (awa_r != `XEVT_OFF_SWT &&
                         awa_r != `XEVT_OFF_PEND) begin
                bresp_nxt = XEVT_SLVERR;
            end
        end
        if (rvld_r && s_axi_rready) begin
            rvld_nxt  = 1'b0;
            arrdy_nxt = 1'b1;
        end
        if (s_axi_arvalid && arrdy_r) begin
            arrdy_nxt = 1'b0;
            rvld_nxt  = 1'b1;
            rresp_nxt = XEVT_OKAY;
            rd_nxt    = `XEVT_RST_WORD;
            if (s_axi_araddr == `XEVT_OFF_IMR) begin
                rd_nxt = {8'h00, imr_r};
            end else if (s_axi_araddr == `XEVT_OFF_EMR) begin
                rd_nxt = {8'h00, emr_r};
            end else if (s_axi_araddr == `XEVT_OFF_RISE) begin
                rd_nxt = {8'h00, rise_r};
            end else if (s_axi_araddr == `XEVT_OFF_FALL) begin
                rd_nxt = {8'h00, fall_r};
            end else if (s_axi_araddr == `XEVT_OFF_PEND) begin
                rd_nxt = {8'h00, pend_r}; // R04
            end else if (s_axi_araddr == `XEVT_OFF_SEL0) begin
                rd_nxt = sel_r[31:0];
            end else if (s_axi_araddr == `XEVT_OFF_SEL1) begin
                rd_nxt = sel_r[63:32];
            end else if (s_axi_araddr != `XEVT_OFF_SWT) begin
                rresp_nxt = XEVT_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imr_r   <= `XEVT_RST_LINE;
            emr_r   <= `XEVT_RST_LINE;
            rise_r  <= `XEVT_RST_LINE;
            fall_r  <= `XEVT_RST_LINE;
            pend_r  <= `XEVT_RST_LINE;
            evt_r   <= `XEVT_RST_LINE;
            req_r   <= `XEVT_RST_LINE;
            irq_r   <= 1'b0;
            sel_r   <= {`XEVT_RST_SEL, `XEVT_RST_SEL};
            run_r   <= 1'b0;
            rs1_r   <= `XEVT_RST_LINE;
            rs2_r   <= `XEVT_RST_LINE;
            rp_r    <= `XEVT_RST_LINE;
            fs1_r   <= `XEVT_RST_LINE;
            fs2_r   <= `XEVT_RST_LINE;
            fp_r    <= `XEVT_RST_LINE;
            awrdy_r <= 1'b1;
            wrdy_r  <= 1'b1;
            bvld_r  <= 1'b0;
            bresp_r <= XEVT_OKAY;
            awa_r   <= '0;
            wd_r    <= `XEVT_RST_WORD;
            ws_r    <= 4'h0;
            arrdy_r <= 1'b1;
            rvld_r  <= 1'b0;
            rd_r    <= `XEVT_RST_WORD;
            rresp_r <= XEVT_OKAY;
        end else if (ce) begin
            // Catchers keep running while frozen, so a lone edge is kept; two same-direction edges cancel
            imr_r   <= imr_nxt;
            emr_r   <= emr_nxt;
            rise_r  <= rise_nxt;
            fall_r  <= fall_nxt;
            pend_r  <= pend_nxt;
            evt_r   <= evt_nxt;
            req_r   <= req_nxt;
            irq_r   <= irq_nxt;
            sel_r   <= sel_nxt;
            run_r   <= run_nxt;
            rs1_r   <= rs1_nxt;
            rs2_r   <= rs2_nxt;
            rp_r    <= rp_nxt;
            fs1_r   <= fs1_nxt;
            fs2_r   <= fs2_nxt;
            fp_r    <= fp_nxt;
            awrdy_r <= awrdy_nxt;
            wrdy_r  <= wrdy_nxt;
            bvld_r  <= bvld_nxt;
            bresp_r <= bresp_nxt;
            awa_r   <= awa_nxt;
            wd_r    <= wd_nxt;
            ws_r    <= ws_nxt;
            arrdy_r <= arrdy_nxt;
            rvld_r  <= rvld_nxt;
            rd_r    <= rd_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_awready = awrdy_r;
    assign s_axi_wready  = wrdy_r;
    assign s_axi_bvalid  = bvld_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arrdy_r;
    assign s_axi_rvalid  = rvld_r;
    assign s_axi_rdata   = rd_r;
    assign s_axi_rresp   = rresp_r;
    assign irq           = irq_r;
    assign line_req      = req_r;
    assign evt_pulse     = evt_r;

    a_pend_set_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && edge_v != '0 |=> (pend_r & $past(edge_v)) == $past(edge_v))
        else $error("edge did not set pending"); // R04
    a_pend_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_v == '0 |=> (pend_r & $past(pend_r)) == $past(pend_r))
        else $error("pending bit dropped without clear"); // R08
    a_trig_select: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> (pend_r & ~$past(pend_r) & ~$past(rise_r | fall_r | swt_v))
               == '0)
        else $error("pending set on unselected edge"); // R02
    a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 imr_r == '0 |-> !irq_r && line_req == '0)
        else $error("request passed a full mask"); // R03
    a_evt_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> evt_pulse == ($past(edge_v) & $past(emr_r)))
        else $error("event pulse mismatch"); // R01
    a_sync_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ((rs2_r ^ rp_r) & rise_r) != '0 |=>
        ($past((rs2_r ^ rp_r) & rise_r) & ~pend_r) == '0)
        else $error("synchronised rising edge lost"); // R05
    a_sel_route: assert property (@(posedge aclk) disable iff (!aresetn)
        sel_r[3:0] == 4'h0 |-> src[0] == gpio_in[0])
        else $error("selector misroutes line zero"); // R06
    a_irq_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 (pend_r & imr_r) != '0 |-> irq_r)
        else $error("irq low with unmasked pending"); // R08
    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");
endmodule
`default_nettype wire

/* src/xevt_cfg.svh */
// Constants of the external line event unit
// How it works
// R01: There are 24 edge lines, each able to raise an interrupt and an event.
// R02: Each line picks rising, falling or both edges on its own.
// R03: Each line has its own interrupt mask, leaving the others untouched.
// R04: Each line has a pending bit, set on its selected edge, readable.
// R05: Edges are caught asynchronously, so pulses shorter than aclk count.
// R06: Lines 0 to 15 each take the same pin index from a selectable port.
// R07: The priority controller downstream arbitrates over 16 levels.
// R08: Pending stays until a one is written; irq stays while pending&unmasked.
`ifndef XEVT_CFG_SVH
`define XEVT_CFG_SVH
`define XEVT_NLINE     24
`define XEVT_NPIN      16
`define XEVT_SELW      4
`define XEVT_AW        8
`define XEVT_OFF_IMR   8'h00
`define XEVT_OFF_EMR   8'h04
`define XEVT_OFF_RISE  8'h08
`define XEVT_OFF_FALL  8'h0c
`define XEVT_OFF_SWT   8'h10
`define XEVT_OFF_PEND  8'h14
`define XEVT_OFF_SEL0  8'h18
`define XEVT_OFF_SEL1  8'h1c
`define XEVT_RST_LINE  24'h000000
`define XEVT_RST_SEL   32'h00000000
`define XEVT_RST_WORD  32'h00000000
`endif

/* src/xevt_pkg.sv */
// Types of the external line event unit
package xevt_pkg;
    typedef enum logic [1:0] {
        XEVT_OKAY   = 2'b00,
        XEVT_SLVERR = 2'b10
    } xevt_resp_t;
endpackage

/* testbench/xevt_prio_model.sv */
// Priority arbiter model standing in for the downstream controller
`include "xevt_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module xevt_prio_model (
    input  wire logic [`XEVT_NLINE-1:0] line_req,
    output logic                        grant_valid,
    output logic [4:0]                  grant_id
);
    logic [4:0] best;
    // Level is the low nibble: 16 levels, a tie goes to the lower line
    always_comb begin
        best = 5'h10;
        grant_id = 5'h00;
        for (int i = 0; i < `XEVT_NLINE; i++) begin
            if (line_req[i] && {1'b0, 4'(i)} < best) begin
                best = {1'b0, 4'(i)};
                grant_id = 5'(i);
            end
        end
        grant_valid = !best[4];
    end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench of the external line event unit
`include "xevt_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import xevt_pkg::*;
    localparam int NP = 8;
    logic             aclk, aresetn, ce;
    logic [NP*16-1:0] gpio_in;
    logic [7:0]       int_line_in, s_axi_awaddr, s_axi_araddr;
    logic [31:0]      s_axi_wdata, s_axi_rdata;
    logic [3:0]       s_axi_wstrb;
    logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic             s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic             s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic             s_axi_rready, irq, grant_valid;
    logic [1:0]       s_axi_bresp, s_axi_rresp;
    logic [23:0]      line_req, evt_pulse;
    logic [4:0]       grant_id;
    int               errors, check_count;

    xevt_top #(.NPORT(NP)) xevt_top_i (.aclk, .aresetn, .ce, .gpio_in,
        .int_line_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq, .line_req, .evt_pulse);
    xevt_prio_model xevt_prio_model_i (.line_req, .grant_valid, .grant_id);

    always #2 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] e;
        e = (a <= `XEVT_OFF_SEL1 && a[1:0] == 2'b00) ? XEVT_OKAY
                                                      : XEVT_SLVERR;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk($sformatf("reg %h", a), e, d);
        chk("rresp", {30'h0, XEVT_OKAY}, {30'h0, r});
    endtask

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        rc(`XEVT_OFF_IMR, 32'h0);
        rc(`XEVT_OFF_RISE, 32'h0);
        rc(`XEVT_OFF_PEND, 32'h0);
        rd(8'h20, d, r);
        chk("unmapped resp", {30'h0, XEVT_SLVERR}, {30'h0, r});
        wr(8'h20, 32'hffffffff);
        rc(`XEVT_OFF_IMR, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test reset done");
    endtask
    task automatic t_edges;
        wr(`XEVT_OFF_RISE, 32'h5);
        wr(`XEVT_OFF_FALL, 32'h6);
        wr(`XEVT_OFF_IMR, 32'h7);
        gpio_in[2:0] <= 3'b111;
        cyc(8);
        rc(`XEVT_OFF_PEND, 32'h5);
        gpio_in[2:0] <= 3'b000;
        cyc(8);
        rc(`XEVT_OFF_PEND, 32'h7);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`XEVT_OFF_PEND, 32'h1);
        rc(`XEVT_OFF_PEND, 32'h6);
        wr(`XEVT_OFF_PEND, 32'h6);
        cyc(2);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test edges done");
    endtask
    task automatic t_mask;
        wr(`XEVT_OFF_IMR, 32'h2);
        // Pulse far shorter than one aclk period
        gpio_in[0] <= 1'b1;
        #1 gpio_in[0] <= 1'b0;
        cyc(8);
        rc(`XEVT_OFF_PEND, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        chk("line_req", 32'h0, {8'h0, line_req});
        wr(`XEVT_OFF_IMR, 32'h1);
        cyc(2);
        chk("irq", 32'h1, {31'h0, irq});
        chk("line_req", 32'h1, {8'h0, line_req});
        wr(`XEVT_OFF_PEND, 32'h1);
        cyc(2);
        chk("irq", 32'h0, {31'h0, irq});
        // Edge while frozen must wait, then land once enabled
        ce <= 1'b0;
        gpio_in[0] <= 1'b1;
        cyc(8);
        chk("irq frozen", 32'h0, {31'h0, irq});
        ce <= 1'b1;
        cyc(8);
        chk("irq thawed", 32'h1, {31'h0, irq});
        wr(`XEVT_OFF_PEND, 32'h1);
        gpio_in[0] <= 1'b0;
        $display("test mask done");
    endtask
    task automatic t_sel;
        wr(`XEVT_OFF_FALL, 32'h0);
        wr(`XEVT_OFF_RISE, 32'h2);
        wr(`XEVT_OFF_SEL0, 32'h20);
        gpio_in[1] <= 1'b1;
        cyc(8);
        rc(`XEVT_OFF_PEND, 32'h0);
        gpio_in[33] <= 1'b1;
        cyc(8);
        rc(`XEVT_OFF_PEND, 32'h2);
        wr(`XEVT_OFF_PEND, 32'h2);
        wr(`XEVT_OFF_SEL0, 32'h0);
        gpio_in <= '0;
        $display("test select done");
    endtask
    task automatic t_int;
        logic [23:0] ev;
        wr(`XEVT_OFF_RISE, 32'h100020);
        wr(`XEVT_OFF_IMR, 32'h100020);
        wr(`XEVT_OFF_EMR, 32'h100000);
        gpio_in[5] <= 1'b1;
        int_line_in[4] <= 1'b1;
        ev = '0;
        repeat (8) begin
            @(posedge aclk);
            ev |= evt_pulse;
        end
        chk("evt_pulse", 32'h100000, {8'h0, ev});
        rc(`XEVT_OFF_PEND, 32'h100020);
        chk("line_req", 32'h100020, {8'h0, line_req});
        // Line 20 sits on level 4, so it beats line 5
        chk("grant", 32'h14, {27'h0, grant_id});
        chk("grant valid", 32'h1, {31'h0, grant_valid});
        wr(`XEVT_OFF_PEND, 32'h100020);
        cyc(2);
        chk("irq", 32'h0, {31'h0, irq});
        chk("grant idle", 32'h0, {31'h0, grant_valid});
        $display("test internal lines done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        ce = 1'b1;
        gpio_in = '0;
        int_line_in = 8'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        errors = 0;
        check_count = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_edges();
        t_mask();
        t_sel();
        t_int();
        results();
    end
    // Whole run needs well under a thousand cycles; this allows 25000
    initial begin
        #100000;
        errors++;
        results();
    end
endmodule
`default_nettype wire
